/* File: core/irqps_pend_bank.sv */
// bank of 32 independent pending flags with set and clear vectors
`timescale 1ns/1ps
`default_nettype none
module irqps_pend_bank
    import irqps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire irqps_vec_t set_i,
    input wire irqps_vec_t clr_i,
    output irqps_vec_t pend_o
);

    irqps_vec_t pend_r;
    irqps_vec_t pend_nxt;

    // ****************************************************************
    // per-bit update
    // ****************************************************************
    // set wins over clear so a request landing with a clear is kept
    assign pend_nxt = (pend_r & ~clr_i) | set_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_r <= IRQPS_PEND_RST;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    assign pend_o = pend_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_set_wins: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (set_i != 32'h0000_0000) |=> ((pend_r & $past(set_i)) ==
                                      $past(set_i)))
        else $error("set bit lost in pending bank");

endmodule : irqps_pend_bank
`default_nettype wire

/* File: core/irqps_pkg.sv */
// constants, carrier types and helpers for the pending set/clear block
package irqps_pkg;

    // ****************************************************************
    // sizes and register map
    // ****************************************************************
    localparam int unsigned IRQPS_NUM_IRQ = 32;
    localparam int unsigned IRQPS_IDX_W = 5;
    localparam int unsigned IRQPS_ADDR_W = 12;
    localparam int unsigned IRQPS_EVT_W = 4;

    localparam logic [11:0] IRQPS_OFF_PEND_SET = 12'h200;
    localparam logic [11:0] IRQPS_OFF_PEND_CLR = 12'h280;
    localparam logic [11:0] IRQPS_OFF_EVT_STAT = 12'h300;
    localparam logic [11:0] IRQPS_OFF_EVT_MASK = 12'h304;

    localparam logic [31:0] IRQPS_PEND_RST = 32'h0000_0000;
    localparam logic [3:0] IRQPS_STAT_RST = 4'h0;
    localparam logic [3:0] IRQPS_MASK_RST = 4'h0;
    localparam logic [31:0] IRQPS_RDATA_RST = 32'h0000_0000;
    localparam logic [4:0] IRQPS_NUM_RST = 5'h00;

    // event bit positions in status and mask
    localparam int unsigned IRQPS_EVT_SW_SET = 0;
    localparam int unsigned IRQPS_EVT_LINE_SET = 1;
    localparam int unsigned IRQPS_EVT_SW_CLR = 2;
    localparam int unsigned IRQPS_EVT_TAKEN = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [31:0] irqps_vec_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } irqps_bus_s;

    typedef enum logic [0:0] {
        IRQPS_IDLE,
        IRQPS_OFFER
    } irqps_disp_e;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic irqps_hit(input logic [11:0] addr,
                                       input logic [11:0] off);
        irqps_hit = (addr == off);
    endfunction : irqps_hit

    // lowest numbered set bit; zero vector gives zero
    function automatic logic [4:0] irqps_first(input irqps_vec_t v);
        logic [4:0] idx;
        idx = IRQPS_NUM_RST;
        for (int i = IRQPS_NUM_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        irqps_first = idx;
    endfunction : irqps_first

    function automatic irqps_vec_t irqps_onehot(input logic [4:0] n);
        irqps_onehot = 32'h0000_0001 << n;
    endfunction : irqps_onehot

endpackage : irqps_pkg

/* File: core/irqps_top.sv */
// pending set/clear logic for 32 interrupt lines with dispatch offer
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module irqps_top
    import irqps_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire irqps_bus_s bus_i,
    output logic [31:0] rdata_o,
    input wire irqps_vec_t irq_line_i,
    input wire irqps_vec_t irq_enable_i,
    input wire irqps_vec_t irq_active_i,
    input wire logic take_ack_i,
    output logic offer_valid_o,
    output logic [4:0] offer_num_o,
    output irqps_vec_t pending_o,
    output logic irq_o
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_b_r;
    logic rst_sync_b_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_b_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_b_r <= 1'b1;
            rst_sync_b_r <= rst_meta_b_r;
        end
    end

    default clocking chk_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_sync_b_r);

    // ****************************************************************
    // address decode
    // ****************************************************************
    wire logic hit_set;
    wire logic hit_clr;
    wire logic hit_stat;
    wire logic hit_mask;
    wire logic wr_set;
    wire logic wr_clr;
    wire logic wr_stat;
    wire logic wr_mask;

    assign hit_set = irqps_hit(bus_i.addr, IRQPS_OFF_PEND_SET);
    assign hit_clr = irqps_hit(bus_i.addr, IRQPS_OFF_PEND_CLR);
    assign hit_stat = irqps_hit(bus_i.addr, IRQPS_OFF_EVT_STAT);
    assign hit_mask = irqps_hit(bus_i.addr, IRQPS_OFF_EVT_MASK);
    assign wr_set = bus_i.wr & hit_set;
    assign wr_clr = bus_i.wr & hit_clr;
    assign wr_stat = bus_i.wr & hit_stat;
    assign wr_mask = bus_i.wr & hit_mask;

    // ****************************************************************
    // pending vectors
    // ****************************************************************
    irqps_vec_t pend_q;
    irqps_vec_t sw_set_vec;
    irqps_vec_t sw_set_dis;
    irqps_vec_t sw_clr_vec;
    irqps_vec_t line_set_vec;
    irqps_vec_t take_clr_vec;
    irqps_vec_t set_all;
    irqps_vec_t clr_all;
    irqps_vec_t chg_mask;
    irqps_vec_t cand_vec;
    wire logic take_now;

    // bit n of the write word aims at interrupt n only
    assign sw_set_vec = wr_set ? bus_i.wdata : IRQPS_PEND_RST;
    // no enable term here: software may pend a disabled line
    assign sw_set_dis = sw_set_vec & ~irq_enable_i;
    assign sw_clr_vec = wr_clr ? bus_i.wdata : IRQPS_PEND_RST;
    // level detection: a held line re-pends only once not active
    assign line_set_vec = irq_line_i & ~irq_active_i;
    assign take_now = offer_valid_o & take_ack_i;
    assign take_clr_vec = take_now ? irqps_onehot(offer_num_o)
                                   : IRQPS_PEND_RST;
    assign set_all = sw_set_vec | line_set_vec;
    assign clr_all = sw_clr_vec | take_clr_vec;
    assign chg_mask = set_all | clr_all;
    // only enabled pending interrupts compete for the core
    assign cand_vec = pend_q & irq_enable_i;

    irqps_pend_bank irqps_pend_bank_i (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_sync_b_r),
        .set_i(set_all),
        .clr_i(clr_all),
        .pend_o(pend_q)
    );

    // ****************************************************************
    // event status, mask and interrupt
    // ****************************************************************
    logic [3:0] stat_r;
    logic [3:0] stat_nxt;
    logic [3:0] mask_r;
    logic irq_r;
    wire logic [3:0] evt;
    wire logic [3:0] stat_w1c;

    // set and clear events fire only for bits not already in the state asked for, taken on every take; a set in the same cycle can still keep the bit
    assign evt[IRQPS_EVT_SW_SET] = |(sw_set_vec & ~pend_q);
    assign evt[IRQPS_EVT_LINE_SET] = |(line_set_vec & ~pend_q);
    assign evt[IRQPS_EVT_SW_CLR] = |(sw_clr_vec & pend_q);
    assign evt[IRQPS_EVT_TAKEN] = take_now;
    assign stat_w1c = wr_stat ? bus_i.wdata[3:0] : IRQPS_STAT_RST;
    // a new event beats a write-one clear in the same cycle
    assign stat_nxt = (stat_r & ~stat_w1c) | evt;

    always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            stat_r <= IRQPS_STAT_RST;
            mask_r <= IRQPS_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= wr_mask ? bus_i.wdata[3:0] : mask_r;
            irq_r <= |(stat_r & mask_r);
        end
    end

    assign irq_o = irq_r;

    // ****************************************************************
    // read port
    // ****************************************************************
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // both pending registers show the same live pending vector
    always_comb begin
        rdata_nxt = IRQPS_RDATA_RST;
        if (hit_set || hit_clr) begin
            rdata_nxt = pend_q;
        end else if (hit_stat) begin
            rdata_nxt = {28'h000_0000, stat_r};
        end else if (hit_mask) begin
            rdata_nxt = {28'h000_0000, mask_r};
        end
    end

    // data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rdata_r <= IRQPS_RDATA_RST;
        end else begin
            rdata_r <= bus_i.rd ? rdata_nxt : IRQPS_RDATA_RST;
        end
    end

    assign rdata_o = rdata_r;
    assign pending_o = pend_q;

    // ****************************************************************
    // dispatch offer
    // ****************************************************************
    irqps_disp_e state_r;
    irqps_disp_e state_nxt;
    logic valid_r;
    logic valid_nxt;
    logic [4:0] num_r;
    logic [4:0] num_nxt;
    wire logic [4:0] first_num;
    wire logic still_cand;

    assign first_num = irqps_first(cand_vec);
    // the offer is withdrawn if its bit is cleared or disabled
    assign still_cand = cand_vec[num_r];

    always_comb begin
        state_nxt = state_r;
        valid_nxt = valid_r;
        num_nxt = num_r;
        case (state_r)
            IRQPS_IDLE: begin
                if (cand_vec != IRQPS_PEND_RST) begin
                    state_nxt = IRQPS_OFFER;
                    valid_nxt = 1'b1;
                    num_nxt = first_num;
                end
            end
            IRQPS_OFFER: begin
                if (take_ack_i || !still_cand) begin
                    state_nxt = IRQPS_IDLE;
                    valid_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = IRQPS_IDLE;
                valid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            state_r <= IRQPS_IDLE;
            valid_r <= 1'b0;
            num_r <= IRQPS_NUM_RST;
        end else begin
            state_r <= state_nxt;
            valid_r <= valid_nxt;
            num_r <= num_nxt;
        end
    end

    assign offer_valid_o = valid_r;
    assign offer_num_o = num_r;

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_set_pends: assert property (
        (sw_set_vec != 32'h0000_0000) |=>
            ((pend_q & $past(sw_set_vec)) == $past(sw_set_vec)))
        else $error("written one did not pend");

    chk_zero_keeps: assert property (
        ##1 (((pend_q ^ $past(pend_q)) & ~$past(chg_mask)) ==
             32'h0000_0000))
        else $error("untouched pending bit changed");

    chk_read_set: assert property (
        (bus_i.rd && hit_set) |=> (rdata_o == $past(pend_q)))
        else $error("set register read wrong");

    chk_read_clr: assert property (
        (bus_i.rd && hit_clr) |=> (rdata_o == $past(pend_q)))
        else $error("clear register read wrong");

    chk_clr_removes: assert property (
        (sw_clr_vec != 32'h0000_0000 && set_all == 32'h0000_0000) |=>
            ((pend_q & $past(sw_clr_vec)) == 32'h0000_0000))
        else $error("written one did not clear pending");

    chk_dis_pends: assert property (
        (sw_set_dis != 32'h0000_0000) |=>
            ((pend_q & $past(sw_set_dis)) == $past(sw_set_dis)))
        else $error("disabled interrupt not pended");

    chk_repend_quiet: assert property (
        (wr_set && (sw_set_vec & ~pend_q) == 32'h0000_0000 &&
         clr_all == 32'h0000_0000 &&
         (line_set_vec & ~pend_q) == 32'h0000_0000) |=>
            (pend_q == $past(pend_q) &&
             stat_r[IRQPS_EVT_SW_SET] == $past(stat_r[IRQPS_EVT_SW_SET])))
        else $error("re-pending changed state");

    chk_top_bit: assert property (
        (wr_set && bus_i.wdata[31]) |=> pend_q[31])
        else $error("bit 31 not mapped");

    chk_offer_enabled: assert property (
        $rose(valid_r) |-> ($past(cand_vec) != 32'h0000_0000))
        else $error("offer without enabled pending");

    chk_offer_follows: assert property (
        (state_r == IRQPS_IDLE && cand_vec != 32'h0000_0000) |=>
            (valid_r && num_r == $past(first_num)))
        else $error("enabled pending not offered");

    chk_irq_level: assert property (
        ((stat_r & mask_r) != 4'h0) |=> irq_o)
        else $error("unmasked event not signalled");

    chk_rdata_idle: assert property (
        !bus_i.rd |=> (rdata_o == 32'h0000_0000))
        else $error("read data stood without a read");

    chk_take_clears: assert property (
        (take_now && (set_all & take_clr_vec) == 32'h0000_0000) |=>
            ((pend_q & $past(take_clr_vec)) == 32'h0000_0000))
        else $error("taken interrupt still pending");

    chk_offer_drops: assert property (
        take_now |=> !valid_r)
        else $error("offer stood after take");

    chk_offer_withdraw: assert property (
        (valid_r && !still_cand) |=> !valid_r)
        else $error("stale offer not withdrawn");

    chk_stat_sticky: assert property (
        (evt != 4'h0) |=> ((stat_r & $past(evt)) == $past(evt)))
        else $error("event did not set status");

    chk_stat_clear: assert property (
        (wr_stat && evt == 4'h0) |=>
            ((stat_r & $past(stat_w1c)) == 4'h0))
        else $error("status write-one did not clear");

    chk_mask_write: assert property (
        wr_mask |=> (mask_r == $past(bus_i.wdata[3:0])))
        else $error("mask write lost");

endmodule : irqps_top
`default_nettype wire

/* File: sim/irqps_core_model.sv */
// behavioural core that takes dispatch offers after a set delay
`timescale 1ns/1ps
`default_nettype none
module irqps_core_model
    import irqps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic offer_valid_i,
    input wire logic [4:0] offer_num_i,
    input wire logic ack_en_i,
    input wire logic [3:0] ack_dly_i,
    input wire logic ret_i,
    output logic take_ack_o,
    output irqps_vec_t active_o
);
    logic [3:0] wait_r;
    // ****************************************************************
    // take logic
    // ****************************************************************
    // acks only while an offer stands, never a stray pulse
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            take_ack_o <= 1'b0;
            wait_r <= 4'h0;
            active_o <= '0;
        end else begin
            if (ret_i) begin
                active_o <= '0;
            end
            if (take_ack_o) begin
                take_ack_o <= 1'b0;
            end else if (offer_valid_i && ack_en_i) begin
                if (wait_r == ack_dly_i) begin
                    take_ack_o <= 1'b1;
                    active_o[offer_num_i] <= 1'b1;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end else begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule : irqps_core_model
`default_nettype wire

/* File: sim/irqps_top_bench.sv */
// self-checking bench for the pending set/clear block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    err_count++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module irqps_top_bench
    import irqps_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    irqps_bus_s bus = '0;
    irqps_vec_t line = '0;
    irqps_vec_t en = '0;
    logic ack_en = 1'b0;
    logic ret = 1'b0;
    logic [3:0] dly = 4'h2;
    logic [31:0] rdata;
    logic offer_valid;
    logic [4:0] offer_num;
    irqps_vec_t pending;
    irqps_vec_t active;
    logic irq;
    logic take_ack;
    int err_count = 0;
    int checks_done = 0;

    always #2.5 sys_clk = ~sys_clk;

    irqps_top irqps_top_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
        .bus_i(bus), .rdata_o(rdata), .irq_line_i(line),
        .irq_enable_i(en), .irq_active_i(active), .take_ack_i(take_ack),
        .offer_valid_o(offer_valid), .offer_num_o(offer_num),
        .pending_o(pending), .irq_o(irq));
    irqps_core_model irqps_core_model_i (.clk_i(sys_clk), .rst_b_i(rst_b),
        .offer_valid_i(offer_valid), .offer_num_i(offer_num),
        .ack_en_i(ack_en), .ack_dly_i(dly), .ret_i(ret),
        .take_ack_o(take_ack), .active_o(active));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus <= '0;
        #1;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task automatic rd_is(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        `CHK(nm, exp, rdata)
    endtask : rd_is

    // bounded wait for the offer flag to reach a level
    task automatic wait_offer(input logic lvl);
        int n;
        n = 0;
        while (offer_valid !== lvl) begin
            tick(1);
            n++;
            if (n > 20) begin
                err_count++;
                $display("BAD offer_valid exp %h got %h", lvl, offer_valid);
                tally_and_finish();
            end
        end
    endtask : wait_offer

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        tick(3);
        `CHK("pend_rst", IRQPS_PEND_RST, pending)
        rd_is("set_rst", IRQPS_OFF_PEND_SET, 32'h0000_0000);
        rd_is("stat_rst", IRQPS_OFF_EVT_STAT, 32'h0000_0000);
        rd_is("mask_rst", IRQPS_OFF_EVT_MASK, 32'h0000_0000);
        reg_wr(12'h100, 32'hffff_ffff);
        rd_is("unmapped", 12'h100, 32'h0000_0000);
        `CHK("unmapped_wr", 32'h0000_0000, pending)
        // software set while every line is disabled
        reg_wr(IRQPS_OFF_PEND_SET, 32'h8000_0021);
        `CHK("pend_set", 32'h8000_0021, pending)
        rd_is("set_rd", IRQPS_OFF_PEND_SET, 32'h8000_0021);
        rd_is("clr_rd", IRQPS_OFF_PEND_CLR, 32'h8000_0021);
        tick(1);
        `CHK("rd_gone", 32'h0000_0000, rdata)
        `CHK("no_offer", 1'b0, offer_valid)
        rd_is("stat_set", IRQPS_OFF_EVT_STAT, 32'h0000_0001);
        reg_wr(IRQPS_OFF_EVT_STAT, 32'h0000_0001);
        reg_wr(IRQPS_OFF_PEND_SET, 32'h8000_0001);
        rd_is("stat_again", IRQPS_OFF_EVT_STAT, 32'h0000_0000);
        `CHK("pend_again", 32'h8000_0021, pending)
        reg_wr(IRQPS_OFF_PEND_SET, 32'h0000_0100);
        `CHK("pend_one", 32'h8000_0121, pending)
        // clear with the clear event unmasked
        reg_wr(IRQPS_OFF_EVT_MASK, 32'h0000_0004);
        reg_wr(IRQPS_OFF_PEND_CLR, 32'h0000_0000);
        `CHK("clr_zero", 32'h8000_0121, pending)
        tick(1);
        `CHK("irq_masked", 1'b0, irq)
        reg_wr(IRQPS_OFF_PEND_CLR, 32'h8000_0100);
        `CHK("pend_clr", 32'h0000_0021, pending)
        tick(1);
        `CHK("irq_up", 1'b1, irq)
        reg_wr(IRQPS_OFF_EVT_STAT, 32'h0000_0004);
        tick(1);
        `CHK("irq_down", 1'b0, irq)
        rd_is("stat_w1c", IRQPS_OFF_EVT_STAT, 32'h0000_0001);
        // dispatch: disabled pending waits, then lowest enabled is taken
        reg_wr(IRQPS_OFF_PEND_CLR, 32'hffff_ffff);
        reg_wr(IRQPS_OFF_PEND_SET, 32'h0000_0220);
        tick(8);
        `CHK("held_off", 1'b0, offer_valid)
        @(posedge sys_clk);
        en <= 32'h0000_0200;
        wait_offer(1'b1);
        `CHK("offer_9", 5'h09, offer_num)
        ack_en <= 1'b1;
        wait_offer(1'b0);
        `CHK("taken_9", 32'h0000_0020, pending)
        rd_is("stat_take", IRQPS_OFF_EVT_STAT, 32'h0000_000d);
        @(posedge sys_clk);
        en <= 32'h0000_0220;
        wait_offer(1'b1);
        `CHK("offer_5", 5'h05, offer_num)
        wait_offer(1'b0);
        `CHK("taken_5", 32'h0000_0000, pending)
        // a disabled line pends but is never offered
        @(posedge sys_clk);
        ack_en <= 1'b0;
        ret <= 1'b1;
        line <= 32'h0000_0080;
        @(posedge sys_clk);
        ret <= 1'b0;
        line <= 32'h0000_0000;
        tick(4);
        `CHK("line_pend", 32'h0000_0080, pending)
        `CHK("line_held", 1'b0, offer_valid)
        rd_is("stat_line", IRQPS_OFF_EVT_STAT, 32'h0000_000f);
        reg_wr(IRQPS_OFF_PEND_CLR, 32'h0000_0080);
        `CHK("line_clr", 32'h0000_0000, pending)
        // an offer is withdrawn once its bit is cleared by software
        reg_wr(IRQPS_OFF_PEND_SET, 32'h0000_0020);
        wait_offer(1'b1);
        `CHK("offer_wd", 5'h05, offer_num)
        reg_wr(IRQPS_OFF_PEND_CLR, 32'h0000_0020);
        wait_offer(1'b0);
        `CHK("wd_pend", 32'h0000_0000, pending)
        tally_and_finish();
    end
endmodule : irqps_top_bench
`default_nettype wire
